// ===== hw/rtcdao_pkg.sv
// Constants shared by the day alarm and frequency correction block
`default_nettype none

package rtcdao_pkg;

  // Register indices; byte address is four times the index
  localparam logic [7:0] IDX_DAY_ALARM = 8'h0C;
  localparam logic [7:0] IDX_WEEKDAY_ALARM = 8'h0D;
  localparam logic [7:0] IDX_FREQ_CORR = 8'h0E;
  localparam logic [7:0] IDX_CONTROL = 8'h10;
  localparam logic [7:0] IDX_IRQ_STATUS = 8'h11;
  localparam logic [7:0] IDX_IRQ_MASK = 8'h12;

  // Field positions
  localparam int DISABLE_BIT = 7;
  localparam int MODE_BIT = 7;
  localparam int DAY_MSB = 5;
  localparam int WEEKDAY_MSB = 2;
  localparam int OFFSET_MSB = 6;
  localparam int CIE_BIT = 0;
  localparam int ST_ALARM_BIT = 0;
  localparam int ST_CORR_BIT = 1;
  localparam int IRQ_BITS = 2;

  // Reset values
  localparam logic [7:0] DAY_ALARM_RST = 8'h80;
  localparam logic [7:0] WEEKDAY_ALARM_RST = 8'h80;
  localparam logic [7:0] FREQ_CORR_RST = 8'h00;
  localparam logic [7:0] CONTROL_RST = 8'h00;
  localparam logic [IRQ_BITS-1:0] IRQ_RST = 2'h0;

  // Timebase figures, in timebase ticks and seconds
  localparam int TICKS_PER_SECOND = 32768;
  localparam int TWO_HOURS_S = 7200;
  localparam int MINUTE_S = 60;
  // Correction cycles per interval per LSB: 4.34 ppm and 4.069 ppm
  localparam int CYCLES_PER_TWO_HOURS = 1024;
  localparam int CYCLES_PER_MINUTE = 8;
  // Interrupt pulse is 1/4096 s
  localparam int INT_PULSE_DIV = 4096;
  localparam int INT_PULSE_TICKS = TICKS_PER_SECOND / INT_PULSE_DIV;
  localparam int PULSE_SPACING_TICKS = 2 * INT_PULSE_TICKS;

  typedef enum logic [1:0] {
    CORR_IDLE = 2'h0,
    CORR_APPLY = 2'h1,
    CORR_SPACE = 2'h2
  } rtcdao_corr_state_t;

endpackage : rtcdao_pkg

`default_nettype wire

// ===== hw/rtcdao_alarm_match.sv
// Day and weekday alarm comparator
`default_nettype none

module rtcdao_alarm_match (
  input wire logic [7:0] day_alarm,
  input wire logic [7:0] weekday_alarm,
  input wire logic [5:0] day_bcd,
  input wire logic [2:0] weekday,
  output logic match
);

  logic day_ok;
  logic weekday_ok;
  logic any_enabled;

  always_comb begin
    // Disabled fields never block a match
    day_ok = day_alarm[rtcdao_pkg::DISABLE_BIT] ||
             (day_alarm[rtcdao_pkg::DAY_MSB:0] == day_bcd);
    weekday_ok = weekday_alarm[rtcdao_pkg::DISABLE_BIT] ||
                 (weekday_alarm[rtcdao_pkg::WEEKDAY_MSB:0] == weekday);
    // With every field disabled there is no alarm at all
    any_enabled = !day_alarm[rtcdao_pkg::DISABLE_BIT] ||
                  !weekday_alarm[rtcdao_pkg::DISABLE_BIT];
    match = day_ok && weekday_ok && any_enabled;
  end

endmodule : rtcdao_alarm_match

`default_nettype wire

// ===== hw/rtcdao_pulse_timer.sv
// Stretches one correction pulse to a 1/4096 s interrupt pulse
`default_nettype none

module rtcdao_pulse_timer (
  input wire logic clk,
  input wire logic rst,
  input wire logic tick,
  input wire logic start,
  output logic active
);

  logic [3:0] remain;

  always_ff @(posedge clk) begin
    if (rst) begin
      remain <= 4'h0;
    end else if (start) begin
      remain <= 4'(rtcdao_pkg::INT_PULSE_TICKS);
    end else if (tick && remain != 4'h0) begin
      remain <= remain - 4'h1;
    end
  end

  assign active = (remain != 4'h0);

endmodule : rtcdao_pulse_timer

`default_nettype wire

// ===== hw/rtcdao_top.sv
// Day alarm, weekday alarm and frequency correction with Wishbone registers
//
// Added by the designer: the Wishbone interface to the registers.
`default_nettype none

// Operation
// - Day alarm bit 7 disables; resets set
// - Day alarm bits 5..0 hold BCD day
// - Weekday alarm bit 7 disables; bits 2..0 weekday
// - Offset bit 7 picks two-hour or minute
// - Offset bits 6..0 signed, reset zero
// - LSB worth 4.34 or 4.069 ppm
// - Correction inserts or removes timebase pulses
// - Correction enable gives 1/4096 s low pulse
// - One interrupt pulse per correction pulse
// - Current day and weekday compared in BCD
module rtcdao_top #(
  parameter int SECOND_TICKS = rtcdao_pkg::TICKS_PER_SECOND,
  parameter int TWO_HOUR_CYCLE_TICKS = rtcdao_pkg::TWO_HOURS_S *
    rtcdao_pkg::TICKS_PER_SECOND / rtcdao_pkg::CYCLES_PER_TWO_HOURS,
  parameter int MINUTE_CYCLE_TICKS = rtcdao_pkg::MINUTE_S *
    rtcdao_pkg::TICKS_PER_SECOND / rtcdao_pkg::CYCLES_PER_MINUTE
) (
  input wire logic CLOCK,
  input wire logic RST,
  input wire logic TICK_32K,
  input wire logic [5:0] DAY_BCD,
  input wire logic [2:0] WEEKDAY,
  input wire logic [7:0] ADR_I,
  input wire logic [31:0] DAT_I,
  input wire logic WE_I,
  input wire logic [3:0] SEL_I,
  input wire logic CYC_I,
  input wire logic STB_I,
  output logic [31:0] DAT_O,
  output logic ACK_O,
  output logic IRQ,
  output logic INT_N,
  output logic ALARM,
  output logic SECOND_TICK
);

  // Registers
  logic [7:0] day_alarm;
  logic [7:0] weekday_alarm;
  logic [7:0] freq_corr;
  logic [7:0] control;
  logic [rtcdao_pkg::IRQ_BITS-1:0] irq_status;
  logic [rtcdao_pkg::IRQ_BITS-1:0] irq_mask;

  // Bus decode
  logic bus_req;
  logic bus_write;
  logic lane0_write;
  logic [7:0] next_read;

  // Correction machinery
  rtcdao_pkg::rtcdao_corr_state_t corr_state;
  rtcdao_pkg::rtcdao_corr_state_t next_corr_state;
  logic [17:0] cycle_cnt;
  logic [17:0] cycle_last;
  logic cycle_end;
  logic [6:0] pending;
  logic [6:0] offset_mag;
  logic insert_mode;
  logic [3:0] gap_cnt;
  logic apply_now;
  logic [16:0] prescaler;
  logic [16:0] next_prescaler;
  logic [1:0] prescaler_inc;
  logic second_wrap;

  // Alarm and interrupt pulse
  logic match;
  logic match_prev;
  logic int_active;
  logic correction_irq_enable;
  logic day_alarm_disable;
  logic weekday_alarm_disable;

  assign correction_irq_enable = control[rtcdao_pkg::CIE_BIT];
  assign day_alarm_disable = day_alarm[rtcdao_pkg::DISABLE_BIT];
  assign weekday_alarm_disable = weekday_alarm[rtcdao_pkg::DISABLE_BIT];

  // Classic Wishbone: ack one cycle after the strobe, dropped the next
  assign bus_req = CYC_I && STB_I && !ACK_O;
  assign bus_write = bus_req && WE_I;
  assign lane0_write = bus_write && SEL_I[0];

  function automatic logic hit(input logic [7:0] adr, input logic [7:0] idx);
    hit = (adr == {idx[5:0], 2'b00});
  endfunction : hit

  always_ff @(posedge CLOCK) begin
    if (RST) begin
      ACK_O <= 1'b0;
    end else begin
      ACK_O <= bus_req;
    end
  end

  always_comb begin
    next_read = 8'h00;
    if (hit(ADR_I, rtcdao_pkg::IDX_DAY_ALARM)) begin
      // Unused bit 6 reads zero
      next_read = {day_alarm_disable, 1'b0, day_alarm[rtcdao_pkg::DAY_MSB:0]};
    end else if (hit(ADR_I, rtcdao_pkg::IDX_WEEKDAY_ALARM)) begin
      next_read = {weekday_alarm_disable, 4'h0,
                   weekday_alarm[rtcdao_pkg::WEEKDAY_MSB:0]};
    end else if (hit(ADR_I, rtcdao_pkg::IDX_FREQ_CORR)) begin
      next_read = freq_corr;
    end else if (hit(ADR_I, rtcdao_pkg::IDX_CONTROL)) begin
      next_read = {7'h00, correction_irq_enable};
    end else if (hit(ADR_I, rtcdao_pkg::IDX_IRQ_STATUS)) begin
      next_read = {6'h00, irq_status};
    end else if (hit(ADR_I, rtcdao_pkg::IDX_IRQ_MASK)) begin
      next_read = {6'h00, irq_mask};
    end
  end

  always_ff @(posedge CLOCK) begin
    if (RST) begin
      DAT_O <= 32'h0000_0000;
    end else if (bus_req && !WE_I) begin
      DAT_O <= {24'h000000, next_read};
    end
  end

  // Alarm registers
  always_ff @(posedge CLOCK) begin
    if (RST) begin
      day_alarm <= rtcdao_pkg::DAY_ALARM_RST;
      weekday_alarm <= rtcdao_pkg::WEEKDAY_ALARM_RST;
    end else begin
      if (lane0_write && hit(ADR_I, rtcdao_pkg::IDX_DAY_ALARM)) begin
        day_alarm <= {DAT_I[rtcdao_pkg::DISABLE_BIT], 1'b0,
                      DAT_I[rtcdao_pkg::DAY_MSB:0]};
      end
      if (lane0_write && hit(ADR_I, rtcdao_pkg::IDX_WEEKDAY_ALARM)) begin
        weekday_alarm <= {DAT_I[rtcdao_pkg::DISABLE_BIT], 4'h0,
                          DAT_I[rtcdao_pkg::WEEKDAY_MSB:0]};
      end
    end
  end

  // Offset and control registers
  always_ff @(posedge CLOCK) begin
    if (RST) begin
      freq_corr <= rtcdao_pkg::FREQ_CORR_RST;
      control <= rtcdao_pkg::CONTROL_RST;
    end else begin
      if (lane0_write && hit(ADR_I, rtcdao_pkg::IDX_FREQ_CORR)) begin
        freq_corr <= DAT_I[7:0];
      end
      if (lane0_write && hit(ADR_I, rtcdao_pkg::IDX_CONTROL)) begin
        control <= {7'h00, DAT_I[rtcdao_pkg::CIE_BIT]};
      end
    end
  end

  // Alarm comparison against the calendar's BCD counters
  rtcdao_alarm_match u_match (
    .day_alarm(day_alarm),
    .weekday_alarm(weekday_alarm),
    .day_bcd(DAY_BCD),
    .weekday(WEEKDAY),
    .match(match)
  );

  always_ff @(posedge CLOCK) begin
    if (RST) begin
      match_prev <= 1'b0;
      ALARM <= 1'b0;
    end else begin
      match_prev <= match;
      ALARM <= match;
    end
  end

  // Correction cycle period depends on the interval mode
  assign cycle_last = freq_corr[rtcdao_pkg::MODE_BIT] ?
                      18'(MINUTE_CYCLE_TICKS - 1) :
                      18'(TWO_HOUR_CYCLE_TICKS - 1);
  assign cycle_end = TICK_32K && (cycle_cnt >= cycle_last);

  // Spreading 1024 or 8 cycles over the interval gives 4.34 or 4.069 ppm per LSB
  always_ff @(posedge CLOCK) begin
    if (RST) begin
      cycle_cnt <= 18'h00000;
    end else if (cycle_end) begin
      cycle_cnt <= 18'h00000;
    end else if (TICK_32K) begin
      cycle_cnt <= cycle_cnt + 18'h00001;
    end
  end

  // Two's complement magnitude; -64 gives 64, which still fits seven bits
  always_comb begin
    if (freq_corr[rtcdao_pkg::OFFSET_MSB]) begin
      offset_mag = 7'(~freq_corr[rtcdao_pkg::OFFSET_MSB:0] + 7'h01);
    end else begin
      offset_mag = freq_corr[rtcdao_pkg::OFFSET_MSB:0];
    end
  end

  always_comb begin
    next_corr_state = corr_state;
    case (corr_state)
      rtcdao_pkg::CORR_IDLE: begin
        if (cycle_end && offset_mag != 7'h00) begin
          next_corr_state = rtcdao_pkg::CORR_APPLY;
        end
      end
      rtcdao_pkg::CORR_APPLY: begin
        if (TICK_32K) begin
          next_corr_state = rtcdao_pkg::CORR_SPACE;
        end
      end
      rtcdao_pkg::CORR_SPACE: begin
        // Applying tick is the first of the spacing, so pulses start 16 ticks apart
        if (TICK_32K && gap_cnt == 4'(rtcdao_pkg::PULSE_SPACING_TICKS - 2)) begin
          // Spacing keeps each interrupt pulse separate
          if (pending == 7'h00) begin
            next_corr_state = rtcdao_pkg::CORR_IDLE;
          end else begin
            next_corr_state = rtcdao_pkg::CORR_APPLY;
          end
        end
      end
      default: begin
        next_corr_state = rtcdao_pkg::CORR_IDLE;
      end
    endcase
  end

  always_ff @(posedge CLOCK) begin
    if (RST) begin
      corr_state <= rtcdao_pkg::CORR_IDLE;
    end else begin
      corr_state <= next_corr_state;
    end
  end

  assign apply_now = (corr_state == rtcdao_pkg::CORR_APPLY) && TICK_32K;

  // Offset is latched at cycle start; a rewrite mid-cycle waits for the next one
  always_ff @(posedge CLOCK) begin
    if (RST) begin
      pending <= 7'h00;
      insert_mode <= 1'b0;
    end else if (corr_state == rtcdao_pkg::CORR_IDLE && cycle_end) begin
      pending <= offset_mag;
      insert_mode <= !freq_corr[rtcdao_pkg::OFFSET_MSB];
    end else if (apply_now) begin
      pending <= pending - 7'h01;
    end
  end

  always_ff @(posedge CLOCK) begin
    if (RST) begin
      gap_cnt <= 4'h0;
    end else if (apply_now) begin
      gap_cnt <= 4'h0;
    end else if (corr_state == rtcdao_pkg::CORR_SPACE && TICK_32K) begin
      gap_cnt <= gap_cnt + 4'h1;
    end
  end

  // Positive offset inserts a pulse and shortens the second; negative removes one
  always_comb begin
    prescaler_inc = 2'h1;
    if (apply_now) begin
      prescaler_inc = insert_mode ? 2'h2 : 2'h0;
    end
    next_prescaler = prescaler + {15'h0000, prescaler_inc};
    second_wrap = TICK_32K && (next_prescaler >= 17'(SECOND_TICKS));
  end

  always_ff @(posedge CLOCK) begin
    if (RST) begin
      prescaler <= 17'h00000;
    end else if (second_wrap) begin
      prescaler <= next_prescaler - 17'(SECOND_TICKS);
    end else if (TICK_32K) begin
      prescaler <= next_prescaler;
    end
  end

  always_ff @(posedge CLOCK) begin
    if (RST) begin
      SECOND_TICK <= 1'b0;
    end else begin
      SECOND_TICK <= second_wrap;
    end
  end

  // One stretched pulse per applied correction pulse
  rtcdao_pulse_timer u_pulse (
    .clk(CLOCK),
    .rst(RST),
    .tick(TICK_32K),
    .start(apply_now),
    .active(int_active)
  );

  always_ff @(posedge CLOCK) begin
    if (RST) begin
      INT_N <= 1'b1;
    end else begin
      INT_N <= !(int_active && correction_irq_enable);
    end
  end

  // Sticky status: a new event beats a simultaneous write-one clear
  always_ff @(posedge CLOCK) begin
    if (RST) begin
      irq_status <= rtcdao_pkg::IRQ_RST;
    end else begin
      if (lane0_write && hit(ADR_I, rtcdao_pkg::IDX_IRQ_STATUS)) begin
        irq_status <= irq_status & ~DAT_I[rtcdao_pkg::IRQ_BITS-1:0];
      end
      if (match && !match_prev) begin
        irq_status[rtcdao_pkg::ST_ALARM_BIT] <= 1'b1;
      end
      if (apply_now) begin
        irq_status[rtcdao_pkg::ST_CORR_BIT] <= 1'b1;
      end
    end
  end

  always_ff @(posedge CLOCK) begin
    if (RST) begin
      irq_mask <= rtcdao_pkg::IRQ_RST;
    end else if (lane0_write && hit(ADR_I, rtcdao_pkg::IDX_IRQ_MASK)) begin
      irq_mask <= DAT_I[rtcdao_pkg::IRQ_BITS-1:0];
    end
  end

  always_ff @(posedge CLOCK) begin
    if (RST) begin
      IRQ <= 1'b0;
    end else begin
      IRQ <= |(irq_status & irq_mask);
    end
  end

endmodule : rtcdao_top

`default_nettype wire

// ===== tb/rtcdao_top_asserts.sv
// Port checks for the day alarm and frequency correction block
`default_nettype none

module rtcdao_top_asserts (
  input wire logic CLOCK,
  input wire logic RST,
  input wire logic TICK_32K,
  input wire logic [5:0] DAY_BCD,
  input wire logic [2:0] WEEKDAY,
  input wire logic WE_I,
  input wire logic CYC_I,
  input wire logic STB_I,
  input wire logic [31:0] DAT_O,
  input wire logic ACK_O,
  input wire logic INT_N,
  input wire logic ALARM,
  input wire logic SECOND_TICK
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] low_ticks;
  logic [8:0] cal_q;
  logic req, wr, cal_chg;
  assign req = CYC_I && STB_I;
  assign wr = req && WE_I;
  assign cal_chg = {DAY_BCD, WEEKDAY} != cal_q;
  always_ff @(posedge CLOCK) begin
    cal_q <= {DAY_BCD, WEEKDAY};
  end
  // Ticks seen while low; width is in timebase ticks, not clocks
  always_ff @(posedge CLOCK) begin
    if (RST || INT_N) begin
      low_ticks <= 4'h0;
    end else if (TICK_32K) begin
      low_ticks <= low_ticks + 4'h1;
    end
  end
  default clocking cb @(posedge CLOCK);
  endclocking
  default disable iff (RST);
  a_ack_taken: assert property (req && !ACK_O |=> ACK_O)
    else $error("request without ack");
  a_ack_single: assert property (ACK_O |=> !ACK_O)
    else $error("ack longer than one cycle");
  a_ack_cause: assert property (ACK_O |-> $past(req))
    else $error("ack without request");
  a_dat_upper: assert property (ACK_O |-> DAT_O[31:8] == 24'h000000)
    else $error("upper read bits set");
  a_int_width: assert property ($rose(INT_N) |-> low_ticks == 4'h8)
    else $error("interrupt pulse width wrong");
  a_int_cause: assert property ($fell(INT_N) |-> $past(TICK_32K, 2))
    else $error("interrupt pulse without tick");
  a_sec_single: assert property (SECOND_TICK |=> !SECOND_TICK)
    else $error("second pulse too long");
  a_sec_cause: assert property (SECOND_TICK |-> $past(TICK_32K))
    else $error("second pulse without tick");
  a_alarm_cause: assert property ($changed(ALARM) |->
    $past(cal_chg) || $past(wr) || $past(wr, 2))
    else $error("alarm moved without cause");
  c_ack: cover property (ACK_O);
  c_int: cover property ($fell(INT_N));
  c_alarm: cover property ($rose(ALARM));
  c_sec: cover property (SECOND_TICK);
endmodule : rtcdao_top_asserts

bind rtcdao_top rtcdao_top_asserts i_rtcdao_top_asserts (
  .CLOCK(CLOCK), .RST(RST), .TICK_32K(TICK_32K), .DAY_BCD(DAY_BCD),
  .WEEKDAY(WEEKDAY), .WE_I(WE_I), .CYC_I(CYC_I), .STB_I(STB_I),
  .DAT_O(DAT_O), .ACK_O(ACK_O), .INT_N(INT_N), .ALARM(ALARM),
  .SECOND_TICK(SECOND_TICK)
);

`default_nettype wire

// ===== tb/rtcdao_top_tb_top.sv
// Register, alarm and correction tests for the day alarm block
`default_nettype none

module rtcdao_top_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic clock = 1'b0;
  logic rst = 1'b1;
  logic tick = 1'b0;
  logic [1:0] div = 2'h0;
  logic [5:0] day = 6'h01;
  logic [2:0] wday = 3'h0;
  logic [7:0] adr = 8'h00;
  logic [31:0] dw = 32'h00000000;
  logic we = 1'b0;
  logic cyc = 1'b0;
  logic [31:0] dr, rd;
  logic ack, irq, int_n, alarm, sec;
  logic int_prev = 1'b1;
  int n_fail = 0;
  int samples_checked = 0;
  int tcnt = 0;
  int fq[$], rq[$], sq[$];

  rtcdao_top #(.SECOND_TICKS(64), .TWO_HOUR_CYCLE_TICKS(300), .MINUTE_CYCLE_TICKS(320))
    i_rtcdao_top (.CLOCK(clock), .RST(rst), .TICK_32K(tick), .DAY_BCD(day),
    .WEEKDAY(wday), .ADR_I(adr), .DAT_I(dw), .WE_I(we), .SEL_I(4'h1), .CYC_I(cyc),
    .STB_I(cyc), .DAT_O(dr), .ACK_O(ack), .IRQ(irq), .INT_N(int_n), .ALARM(alarm),
    .SECOND_TICK(sec));

  initial begin
    forever #2 clock = ~clock;
  end
  // Timebase tick every 4 clocks keeps the run short
  always @(posedge clock) begin
    div <= div + 2'h1;
    tick <= div == 2'h3;
    int_prev <= int_n;
    if (tick) tcnt <= tcnt + 1;
    if (int_prev === 1'b1 && int_n === 1'b0) fq.push_back(tcnt);
    if (int_prev === 1'b0 && int_n === 1'b1) rq.push_back(tcnt);
    if (sec === 1'b1) sq.push_back(tcnt);
  end

  task automatic tally_and_finish();
    $display("checked %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : tally_and_finish

  task automatic check_val(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_fail++;
      $display("unexpected at %0t: value %h not %h", $time, got, exp);
    end
  endtask : check_val

  task automatic check_num(input int got, input int exp);
    samples_checked++;
    if (got != exp) begin
      n_fail++;
      $display("unexpected at %0t: count %0d not %0d", $time, got, exp);
    end
  endtask : check_num

  task automatic bus(input logic [7:0] a, input logic w, input logic [7:0] d);
    int k;
    k = 0;
    @(posedge clock);
    adr <= a;
    we <= w;
    dw <= {24'h000000, d};
    cyc <= 1'b1;
    @(posedge clock);
    while (ack !== 1'b1 && k < 50) begin
      @(posedge clock);
      k++;
    end
    rd = dr;
    cyc <= 1'b0;
    if (k >= 50) begin
      n_fail++;
      $display("unexpected at %0t: bus timeout", $time);
      tally_and_finish();
    end
  endtask : bus

  task automatic rdc(input logic [7:0] a, input logic [7:0] exp);
    bus(a, 1'b0, 8'h00);
    check_val(rd, {24'h000000, exp});
  endtask : rdc

  task automatic ticks(input int n);
    repeat (n * 4) @(posedge clock);
    fq.delete();
    rq.delete();
    sq.delete();
  endtask : ticks

  function automatic int span(input bit want_max);
    int r;
    r = want_max ? 0 : 1000;
    for (int i = 1; i < sq.size(); i++) begin
      if (want_max ? sq[i] - sq[i-1] > r : sq[i] - sq[i-1] < r) r = sq[i] - sq[i-1];
    end
    return r;
  endfunction : span

  initial begin
    repeat (100000) @(posedge clock);
    n_fail++;
    $display("unexpected at %0t: run timeout", $time);
    tally_and_finish();
  end

  initial begin
    repeat (4) @(posedge clock);
    rst <= 1'b0;
    rdc(8'h30, 8'h80);
    rdc(8'h34, 8'h80);
    rdc(8'h38, 8'h00);
    rdc(8'h3C, 8'h00);
    bus(8'h30, 1'b1, 8'h7F);
    rdc(8'h30, 8'h3F);
    bus(8'h34, 1'b1, 8'hFF);
    rdc(8'h34, 8'h87);
    bus(8'h38, 1'b1, 8'hC1);
    rdc(8'h38, 8'hC1);
    bus(8'h38, 1'b1, 8'h00);
    $display("registers done");
    bus(8'h48, 1'b1, 8'h03);
    bus(8'h34, 1'b1, 8'h80);
    bus(8'h30, 1'b1, 8'h31);
    day <= 6'h31;
    repeat (3) @(posedge clock);
    check_val({31'h0, alarm}, 32'h1);
    rdc(8'h44, 8'h01);
    check_val({31'h0, irq}, 32'h1);
    bus(8'h44, 1'b1, 8'h01);
    rdc(8'h44, 8'h00);
    check_val({31'h0, irq}, 32'h0);
    bus(8'h34, 1'b1, 8'h04);
    repeat (3) @(posedge clock);
    check_val({31'h0, alarm}, 32'h0);
    wday <= 3'h4;
    repeat (3) @(posedge clock);
    check_val({31'h0, alarm}, 32'h1);
    day <= 6'h30;
    repeat (3) @(posedge clock);
    check_val({31'h0, alarm}, 32'h0);
    $display("alarm done");
    bus(8'h40, 1'b1, 8'h01);
    bus(8'h44, 1'b1, 8'h03);
    bus(8'h48, 1'b1, 8'h02);
    bus(8'h38, 1'b1, 8'h03);
    fq.delete();
    rq.delete();
    repeat (1400) @(posedge clock);
    check_num(fq.size(), 3);
    check_num(fq[1] - fq[0], 16);
    check_num(fq[2] - fq[0], 32);
    check_num(rq[0] - fq[0], 8);
    rdc(8'h44, 8'h02);
    check_val({31'h0, irq}, 32'h1);
    $display("burst done");
    bus(8'h38, 1'b1, 8'h81);
    ticks(700);
    repeat (2800) @(posedge clock);
    check_num(fq[1] - fq[0], 320);
    check_num(span(1'b0), 63);
    bus(8'h38, 1'b1, 8'hFF);
    ticks(700);
    // Two correction cycles in the window, so one lengthened second lies fully inside
    repeat (2800) @(posedge clock);
    check_num(span(1'b1), 65);
    $display("correction done");
    tally_and_finish();
  end
endmodule : rtcdao_top_tb_top

`default_nettype wire
